//--- dv/gdi_host_model.sv
`timescale 1ns/1ps
module gdi_host_model
(
    input wire logic i_pin_o,
    input wire logic i_pin_oe,
    input wire logic i_pol,
    output logic o_seen
);
    logic level;
    assign level = i_pin_oe ? i_pin_o : 1'b1;
    assign o_seen = (level == i_pol);
endmodule : gdi_host_model

//--- dv/gdi_top_checker.sv
`timescale 1ns/1ps
module gdi_top_checker
#(
    parameter int PULSE_CYCLES = 4,
    parameter int ST_CYCLES = 200
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire gdi_pkg::gdi_addr_t i_addr,
    input wire gdi_pkg::gdi_byte_t i_wdata,
    input wire logic i_new_sample,
    input wire logic o_rd_valid,
    input wire logic o_irq_pin_a_o,
    input wire logic o_irq_pin_a_oe,
    input wire logic o_irq_pin_b_o,
    input wire logic o_irq_pin_b_oe
);
    import gdi_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic en_q, ra_q, rb_q, act_a, act_b;
    logic [3:0] cfg_q;
    // Shadow of the registers the pins depend on
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            en_q <= 1'b0;
            ra_q <= 1'b0;
            rb_q <= 1'b0;
            cfg_q <= 4'h0;
        end
        else if (i_ce && i_wr_en)
        begin
            if (i_addr == 7'h15)
                en_q <= i_wdata[7];
            if (i_addr == 7'h16)
                cfg_q <= i_wdata[3:0];
            if (i_addr == 7'h18)
            begin
                ra_q <= i_wdata[0];
                rb_q <= i_wdata[7];
            end
        end
    end
    // A released line reads high through the board pull-up
    assign act_a = ((o_irq_pin_a_oe ? o_irq_pin_a_o : 1'b1) == cfg_q[0]);
    assign act_b = ((o_irq_pin_b_oe ? o_irq_pin_b_o : 1'b1) == cfg_q[2]);
    property p_rd_valid;
        i_ce && i_rd_en |=> o_rd_valid;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("no read valid");
    property p_en_off;
        !en_q && !$past(en_q) && $stable(cfg_q) |-> !act_a && !act_b;
    endproperty
    a_en_off: assert property (p_en_off) else $error("pin on");
    property p_a_idle;
        !ra_q && !$past(ra_q) && $stable(cfg_q) |-> !act_a;
    endproperty
    a_a_idle: assert property (p_a_idle) else $error("a on");
    property p_b_idle;
        !rb_q && !$past(rb_q) && $stable(cfg_q) |-> !act_b;
    endproperty
    a_b_idle: assert property (p_b_idle) else $error("b on");
    property p_a_hit;
        i_ce && i_new_sample && en_q && ra_q |-> ##[2:3] act_a;
    endproperty
    a_a_hit: assert property (p_a_hit) else $error("a miss");
    property p_b_hit;
        i_ce && i_new_sample && en_q && rb_q |-> ##[2:3] act_b;
    endproperty
    a_b_hit: assert property (p_b_hit) else $error("b miss");
    property p_a_drv;
        $stable(cfg_q) |-> (cfg_q[1] ? !(o_irq_pin_a_oe && o_irq_pin_a_o)
            : o_irq_pin_a_oe);
    endproperty
    a_a_drv: assert property (p_a_drv) else $error("a drive");
    property p_b_drv;
        $stable(cfg_q) |-> (cfg_q[3] ? !(o_irq_pin_b_oe && o_irq_pin_b_o)
            : o_irq_pin_b_oe);
    endproperty
    a_b_drv: assert property (p_b_drv) else $error("b drive");
endmodule : gdi_top_checker

bind gdi_top gdi_top_checker
#(
    .PULSE_CYCLES(PULSE_CYCLES),
    .ST_CYCLES(ST_CYCLES)
)
i_chk
(
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_new_sample(i_new_sample), .o_rd_valid(o_rd_valid),
    .o_irq_pin_a_o(o_irq_pin_a_o), .o_irq_pin_a_oe(o_irq_pin_a_oe),
    .o_irq_pin_b_o(o_irq_pin_b_o), .o_irq_pin_b_oe(o_irq_pin_b_oe)
);

//--- dv/gyro_drdy_irq_and_selftest_tb_top.sv
`timescale 1ns/1ps
module gyro_drdy_irq_and_selftest_tb_top;
    import gdi_pkg::*;
    // Short counts keep the run brief
    localparam int PC = 3;
    localparam int SC = 8;
    logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, ns = 1'b0;
    logic stf = 1'b0, rok = 1'b0, ce = 1'b1, rv, ao, aoe, bo, boe, sa, sb;
    logic [3:0] cfg = 4'h0;
    gdi_addr_t addr = 7'h00;
    gdi_byte_t wd = 8'h00, rdata;
    int err_count = 0, n_tests = 0, cyc = 0, ca, cb, xa, xb;

    always #25 clk = ~clk;

    gdi_top #(.PULSE_CYCLES(PC), .ST_CYCLES(SC)) i_dut
    (
        .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_wr_en(we),
        .i_rd_en(re), .i_addr(addr), .i_wdata(wd), .i_new_sample(ns),
        .i_st_core_fail(stf), .i_rate_ok(rok), .o_rdata(rdata),
        .o_rd_valid(rv), .o_irq_pin_a_o(ao), .o_irq_pin_a_oe(aoe),
        .o_irq_pin_b_o(bo), .o_irq_pin_b_oe(boe)
    );
    gdi_host_model i_host_a
    (
        .i_pin_o(ao), .i_pin_oe(aoe), .i_pol(cfg[0]), .o_seen(sa)
    );
    gdi_host_model i_host_b
    (
        .i_pin_o(bo), .i_pin_oe(boe), .i_pol(cfg[2]), .o_seen(sb)
    );

    task automatic chk(input gdi_byte_t seen, input gdi_byte_t exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input gdi_addr_t a, input gdi_byte_t d);
        @(negedge clk);
        we = 1'b1;
        addr = a;
        wd = d;
        @(negedge clk);
        we = 1'b0;
    endtask : wr

    task automatic rd(input gdi_addr_t a, input gdi_byte_t exp);
        @(negedge clk);
        re = 1'b1;
        addr = a;
        @(negedge clk);
        re = 1'b0;
        chk({7'h00, rv}, 8'h01);
        chk(rdata, exp);
    endtask : rd

    // A second sample one cycle later stretches the pulse by one
    task automatic burst(input logic two);
        ca = 0;
        cb = 0;
        @(negedge clk);
        ns = 1'b1;
        @(negedge clk);
        ns = two;
        // The pin shows active from the second edge after the sample
        repeat (13)
        begin
            @(negedge clk);
            ns = 1'b0;
            ca += int'(sa);
            cb += int'(sb);
        end
    endtask : burst

    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            results();
        end
    end

    initial
    begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        rd(7'h15, 8'h00);
        rd(7'h16, 8'h00);
        rd(7'h18, 8'h00);
        rd(7'h3C, 8'h00);
        rd(7'h20, 8'h00);
        wr(7'h16, 8'hFF);
        rd(7'h16, 8'h0F);
        wr(7'h18, 8'h81);
        rd(7'h18, 8'h81);
        // Clock enable low must freeze the registers
        ce = 1'b0;
        wr(7'h18, 8'h00);
        ce = 1'b1;
        rd(7'h18, 8'h81);
        $display("test registers done");
        for (int e = 0; e < 2; e++)
            for (int r = 0; r < 4; r++)
                for (int c = 0; c < 16; c++)
                begin
                    cfg = c[3:0];
                    wr(7'h16, {4'h0, cfg});
                    wr(7'h18, {r[1], 6'h00, r[0]});
                    wr(7'h15, {e[0], 7'h00});
                    burst(c[1]);
                    xa = (e == 1 && r[0]) ? PC + c[1] : 0;
                    xb = (e == 1 && r[1]) ? PC + c[1] : 0;
                    chk(8'(ca), 8'(xa));
                    chk(8'(cb), 8'(xb));
                end
        $display("test pins done");
        rok = 1'b1;
        stf = 1'b1;
        rd(7'h3C, 8'h10);
        wr(7'h3C, 8'h01);
        rd(7'h3C, 8'h10);
        // Retrigger mid-run must not restart the count
        wr(7'h3C, 8'h01);
        repeat (SC - 3) @(negedge clk);
        rd(7'h3C, 8'h16);
        stf = 1'b0;
        wr(7'h3C, 8'h01);
        rd(7'h3C, 8'h10);
        repeat (SC + 1) @(negedge clk);
        rd(7'h3C, 8'h12);
        $display("test selftest done");
        results();
    end
endmodule : gyro_drdy_irq_and_selftest_tb_top

//--- hdl/gdi_defines.svh
`ifndef GDI_DEFINES_SVH
`define GDI_DEFINES_SVH

// Register offsets on the 7-bit register port
`define GDI_OFS_DRDY_EN 7'h15
`define GDI_OFS_PIN_CFG 7'h16
`define GDI_OFS_ROUTE 7'h18
`define GDI_OFS_SELFTEST 7'h3C

// Data-ready enable register
`define GDI_DRDY_EN_BIT 7
`define GDI_RST_DRDY_EN 8'h00

// Pin configuration register fields
`define GDI_CFG_B_OD_BIT 3
`define GDI_CFG_B_LVL_BIT 2
`define GDI_CFG_A_OD_BIT 1
`define GDI_CFG_A_LVL_BIT 0
`define GDI_CFG_W 4
`define GDI_RST_PIN_CFG 4'h0

// Routing register fields
`define GDI_ROUTE_A_BIT 0
`define GDI_ROUTE_B_BIT 7
`define GDI_RST_ROUTE 8'h00

// Self-test register fields
`define GDI_ST_TRIG_BIT 0
`define GDI_ST_RDY_BIT 1
`define GDI_ST_FAIL_BIT 2
`define GDI_ST_RATE_OK_BIT 4

// Timing
`define GDI_CLK_PERIOD_NS 50
`define GDI_ST_TIME_NS 10000
`define GDI_PULSE_TIME_NS 200

`endif

//--- hdl/gdi_pin_drv.sv
`timescale 1ns/1ps
module gdi_pin_drv
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    gdi_pin_if.drv pin
);
    import gdi_pkg::*;

    typedef struct packed
    {
        logic o;
        logic oe;
    } gdi_drv_state_t;

    gdi_drv_state_t r_q;
    gdi_drv_state_t r_d;
    logic lvl;

    always_comb
    begin
        r_d = r_q;
        lvl = pin.active ? pin.polarity : ~pin.polarity;
        // Open-drain can only pull low; a high level is left to the pull-up
        if (pin.drive_type)
        begin
            r_d.o = 1'b0;
            r_d.oe = ~lvl;
        end
        else
        begin
            r_d.o = lvl;
            r_d.oe = 1'b1;
        end
    end

    // Reset value matches push-pull, active low, idle
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            r_q <= '{o: 1'b1, oe: 1'b1};
        end
        else if (i_ce)
        begin
            r_q <= r_d;
        end
    end

    assign pin.pin_o = r_q.o;
    assign pin.pin_oe = r_q.oe;
endmodule : gdi_pin_drv

//--- hdl/gdi_pin_if.sv
`timescale 1ns/1ps
interface gdi_pin_if;
    logic active;
    logic drive_type;
    logic polarity;
    logic pin_o;
    logic pin_oe;

    modport ctrl
    (
        output active,
        output drive_type,
        output polarity,
        input pin_o,
        input pin_oe
    );

    modport drv
    (
        input active,
        input drive_type,
        input polarity,
        output pin_o,
        output pin_oe
    );
endinterface : gdi_pin_if

//--- hdl/gdi_pkg.sv
package gdi_pkg;

    typedef logic [6:0] gdi_addr_t;
    typedef logic [7:0] gdi_byte_t;

    typedef enum logic [1:0]
    {
        GDI_ST_IDLE = 2'b01,
        GDI_ST_RUN = 2'b10
    } gdi_st_state_t;

endpackage : gdi_pkg

//--- hdl/gdi_selftest.sv
`timescale 1ns/1ps
`include "gdi_defines.svh"
module gdi_selftest
#(
    parameter int ST_CYCLES = 200
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_trig,
    input wire logic i_core_fail,
    output logic o_busy,
    output logic o_rdy,
    output logic o_fail
);
    import gdi_pkg::*;

    localparam int CW = $clog2(ST_CYCLES + 1);

    generate
        if (ST_CYCLES < 1)
        begin : g_bad_cycles
            $error("gdi_selftest: ST_CYCLES must be at least 1");
        end
    endgenerate

    typedef struct packed
    {
        gdi_st_state_t state;
        logic [CW-1:0] cnt;
        logic rdy;
        logic fail;
    } gdi_st_reg_t;

    gdi_st_reg_t r_q;
    gdi_st_reg_t r_d;

    always_comb
    begin
        r_d = r_q;
        unique case (r_q.state)
            GDI_ST_IDLE:
            begin
                if (i_trig)
                begin
                    r_d.state = GDI_ST_RUN;
                    r_d.cnt = CW'(ST_CYCLES);
                    r_d.rdy = 1'b0;
                    r_d.fail = 1'b0;
                end
            end
            GDI_ST_RUN:
            begin
                // Triggers during a run are ignored so the result is not torn
                if (r_q.cnt == CW'(1))
                begin
                    r_d.state = GDI_ST_IDLE;
                    r_d.cnt = '0;
                    r_d.rdy = 1'b1;
                    r_d.fail = i_core_fail;
                end
                else
                begin
                    r_d.cnt = r_q.cnt - CW'(1);
                end
            end
            default:
            begin
                r_d.state = GDI_ST_IDLE;
                r_d.cnt = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            r_q <= '{state: GDI_ST_IDLE, cnt: '0, rdy: 1'b0, fail: 1'b0};
        end
        else if (i_ce)
        begin
            r_q <= r_d;
        end
    end

    assign o_busy = (r_q.state == GDI_ST_RUN);
    assign o_rdy = r_q.rdy;
    assign o_fail = r_q.fail;
endmodule : gdi_selftest

//--- hdl/gdi_top.sv
`timescale 1ns/1ps
`include "gdi_defines.svh"
// How it works
// - Enable zero blocks every data-ready event
// - Enable code raises event per new sample
// - Config bit 3: pin B push-pull/open-drain
// - Config bit 2: pin B active low/high
// - Config bit 1: pin A push-pull/open-drain
// - Config bit 0: pin A active low/high
// - Route zero: event reaches no pin
// - Route 0x01: event on pin A only
// - Route 0x80: event on pin B only
// - Route 0x81: event on both pins
// - Writing trigger bit starts the self-test
// - Ready bit set when self-test finishes
// - Fail bit gives result once ready
// - Rate-ok bit shows proper sensor operation
module gdi_top
#(
    parameter int PULSE_CYCLES =
        (`GDI_PULSE_TIME_NS + `GDI_CLK_PERIOD_NS - 1) / `GDI_CLK_PERIOD_NS,
    parameter int ST_CYCLES =
        (`GDI_ST_TIME_NS + `GDI_CLK_PERIOD_NS - 1) / `GDI_CLK_PERIOD_NS
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire gdi_pkg::gdi_addr_t i_addr,
    input wire gdi_pkg::gdi_byte_t i_wdata,
    input wire logic i_new_sample,
    input wire logic i_st_core_fail,
    input wire logic i_rate_ok,
    output gdi_pkg::gdi_byte_t o_rdata,
    output logic o_rd_valid,
    output logic o_irq_pin_a_o,
    output logic o_irq_pin_a_oe,
    output logic o_irq_pin_b_o,
    output logic o_irq_pin_b_oe
);
    import gdi_pkg::*;

    localparam int PW = $clog2(PULSE_CYCLES + 1);

    generate
        if (PULSE_CYCLES < 1)
        begin : g_bad_pulse
            $error("gdi_top: PULSE_CYCLES must be at least 1");
        end
        if (ST_CYCLES < 1)
        begin : g_bad_st
            $error("gdi_top: ST_CYCLES must be at least 1");
        end
        // Readback pads the field with zeros, so it must stay below a byte
        if (`GDI_CFG_W < 4 || `GDI_CFG_W > 7)
        begin : g_bad_cfg_w
            $error("gdi_top: pin configuration field must be 4 to 7 bits");
        end
    endgenerate

    typedef struct packed
    {
        gdi_byte_t drdy_en;
        logic [`GDI_CFG_W-1:0] pin_cfg;
        gdi_byte_t route;
        logic rate_ok;
        logic [PW-1:0] cnt_a;
        logic [PW-1:0] cnt_b;
        gdi_byte_t rdata;
        logic rd_valid;
    } gdi_top_state_t;

    function automatic logic hit(input gdi_addr_t addr,
                                 input gdi_addr_t ofs);
        hit = (addr == ofs);
    endfunction : hit

    // Restart on a new event, otherwise count the pulse down
    function automatic logic [PW-1:0] pulse_next(input logic start,
                                                 input logic [PW-1:0] cnt);
        if (start)
        begin
            pulse_next = PW'(PULSE_CYCLES);
        end
        else if (cnt != '0)
        begin
            pulse_next = cnt - PW'(1);
        end
        else
        begin
            pulse_next = '0;
        end
    endfunction : pulse_next

    // A pin is live only while its pulse runs and the event may reach it
    function automatic logic pin_live(input logic [PW-1:0] cnt,
                                      input logic en,
                                      input logic routed);
        pin_live = (cnt != '0) && en && routed;
    endfunction : pin_live

    // Reset release through two flops; assertion stays asynchronous
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_sync_q <= 2'b00;
        end
        else if (i_ce)
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    gdi_top_state_t r_q;
    gdi_top_state_t r_d;

    logic wr_en_reg;
    logic wr_cfg_reg;
    logic wr_route_reg;
    logic st_trig;
    logic drdy_on;
    logic evt;
    logic route_a;
    logic route_b;
    logic st_busy;
    logic st_rdy;
    logic st_fail;
    gdi_byte_t rd_mux;

    gdi_pin_if pin_a ();
    gdi_pin_if pin_b ();

    assign wr_en_reg = i_wr_en && hit(i_addr, `GDI_OFS_DRDY_EN);
    assign wr_cfg_reg = i_wr_en && hit(i_addr, `GDI_OFS_PIN_CFG);
    assign wr_route_reg = i_wr_en && hit(i_addr, `GDI_OFS_ROUTE);

    // Trigger bit write
    // A trigger during a run is refused here as well as in the sequencer
    assign st_trig = i_wr_en && hit(i_addr, `GDI_OFS_SELFTEST) &&
                     i_wdata[`GDI_ST_TRIG_BIT] && !st_busy;

    assign drdy_on = r_q.drdy_en[`GDI_DRDY_EN_BIT];

    assign evt = i_new_sample && drdy_on;

    assign route_a = r_q.route[`GDI_ROUTE_A_BIT];
    assign route_b = r_q.route[`GDI_ROUTE_B_BIT];

    always_comb
    begin
        rd_mux = '0;
        if (hit(i_addr, `GDI_OFS_DRDY_EN))
        begin
            rd_mux = r_q.drdy_en;
        end
        else if (hit(i_addr, `GDI_OFS_PIN_CFG))
        begin
            rd_mux = {{(8 - `GDI_CFG_W){1'b0}}, r_q.pin_cfg};
        end
        else if (hit(i_addr, `GDI_OFS_ROUTE))
        begin
            rd_mux = r_q.route;
        end
        else if (hit(i_addr, `GDI_OFS_SELFTEST))
        begin
            // The trigger bit is write-only and reads as zero
            // Ready bit readback
            rd_mux[`GDI_ST_RDY_BIT] = st_rdy;
            rd_mux[`GDI_ST_FAIL_BIT] = st_fail;
            rd_mux[`GDI_ST_RATE_OK_BIT] = r_q.rate_ok;
        end
    end

    always_comb
    begin
        r_d = r_q;
        if (wr_en_reg)
        begin
            r_d.drdy_en = i_wdata;
        end
        if (wr_cfg_reg)
        begin
            r_d.pin_cfg = i_wdata[`GDI_CFG_W-1:0];
        end
        if (wr_route_reg)
        begin
            r_d.route = i_wdata;
        end
        r_d.rate_ok = i_rate_ok;

        r_d.cnt_a = pulse_next(evt && route_a, r_q.cnt_a);
        r_d.cnt_b = pulse_next(evt && route_b, r_q.cnt_b);

        // Read data is registered, valid one cycle after the request
        r_d.rd_valid = i_rd_en;
        if (i_rd_en)
        begin
            r_d.rdata = rd_mux;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_q <= '{drdy_en: `GDI_RST_DRDY_EN,
                     pin_cfg: `GDI_RST_PIN_CFG,
                     route: `GDI_RST_ROUTE,
                     rate_ok: 1'b0,
                     cnt_a: '0,
                     cnt_b: '0,
                     rdata: '0,
                     rd_valid: 1'b0};
        end
        else if (i_ce)
        begin
            r_q <= r_d;
        end
    end

    assign pin_a.active = pin_live(r_q.cnt_a, drdy_on, route_a);
    assign pin_b.active = pin_live(r_q.cnt_b, drdy_on, route_b);

    assign pin_a.drive_type = r_q.pin_cfg[`GDI_CFG_A_OD_BIT];
    assign pin_a.polarity = r_q.pin_cfg[`GDI_CFG_A_LVL_BIT];
    assign pin_b.drive_type = r_q.pin_cfg[`GDI_CFG_B_OD_BIT];
    assign pin_b.polarity = r_q.pin_cfg[`GDI_CFG_B_LVL_BIT];

    gdi_pin_drv u_pin_a
    (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .pin(pin_a)
    );

    gdi_pin_drv u_pin_b
    (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .pin(pin_b)
    );

    gdi_selftest #(
        .ST_CYCLES(ST_CYCLES)
    ) u_selftest
    (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_trig(st_trig),
        .i_core_fail(i_st_core_fail),
        .o_busy(st_busy),
        .o_rdy(st_rdy),
        .o_fail(st_fail)
    );

    assign o_rdata = r_q.rdata;
    assign o_rd_valid = r_q.rd_valid;
    assign o_irq_pin_a_o = pin_a.pin_o;
    assign o_irq_pin_a_oe = pin_a.pin_oe;
    assign o_irq_pin_b_o = pin_b.pin_o;
    assign o_irq_pin_b_oe = pin_b.pin_oe;
endmodule : gdi_top
